// [rtl/arm_cnt_if.sv]
// Link between the rule qualifier and one per-port event counter
`timescale 1ns/100ps
interface arm_cnt_if;
    logic                      active;
    logic                      count_up;
    logic                      tick;
    logic                      hit;
    logic [arm_pkg::CNT_W-1:0] load_value;
    logic                      expire;
    logic [arm_pkg::CNT_W-1:0] count;

    modport ctl (
        output active,
        output count_up,
        output tick,
        output hit,
        output load_value,
        input  expire,
        input  count
    );

    modport counter (
        input  active,
        input  count_up,
        input  tick,
        input  hit,
        input  load_value,
        output expire,
        output count
    );
endinterface

// [rtl/arm_event_counter.sv]
// Timeout or packet-count counter for one port
`timescale 1ns/100ps
module arm_event_counter (
    input  wire logic  i_clk,
    input  wire logic  i_reset,
    arm_cnt_if.counter cif
);
    import arm_pkg::*;

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             expire_ff;
    logic             nxt_expire;
    logic             active_ff;
    logic             up_ff;
    wire logic        restart;
    wire logic [CNT_W:0] inc;
    wire logic        terminal_up;
    wire logic        down_last;

    // Mode change mid-count restarts cleanly rather than mixing algorithms
    assign restart     = !cif.active || !active_ff || (cif.count_up != up_ff);
    assign inc         = {1'b0, cnt_ff} + {{CNT_W{1'b0}}, 1'b1};
    assign terminal_up = inc >= {1'b0, cif.load_value};
    assign down_last   = cnt_ff <= {{(CNT_W-1){1'b0}}, 1'b1};

    always_comb begin
        nxt_cnt    = cnt_ff;
        nxt_expire = 1'b0;
        if (restart) begin
            nxt_cnt = cif.count_up ? {CNT_W{1'b0}} : cif.load_value;
        end else if (cif.count_up) begin
            if (cif.hit) begin
                if (terminal_up) begin
                    nxt_expire = 1'b1; // [R4]
                    nxt_cnt    = {CNT_W{1'b0}}; // [R4]
                end else begin
                    nxt_cnt = inc[CNT_W-1:0]; // [R4]
                end
            end
        end else if (cif.hit) begin
            nxt_cnt = cif.load_value; // [R3]
        end else if (cif.tick) begin
            if (down_last) begin
                nxt_expire = 1'b1; // [R3]
                nxt_cnt    = cif.load_value; // [R3]
            end else begin
                nxt_cnt = cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1}; // [R3]
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cnt_ff    <= {CNT_W{1'b0}};
            expire_ff <= 1'b0;
            active_ff <= 1'b0;
            up_ff     <= 1'b0;
        end else begin
            cnt_ff    <= nxt_cnt;
            expire_ff <= nxt_expire; // [R14]
            active_ff <= cif.active;
            up_ff     <= cif.count_up;
        end
    end

    assign cif.expire = expire_ff;
    assign cif.count  = cnt_ff;

    a_down_expire: assert property (@(posedge i_clk) disable iff (i_reset) // [R3]
        (!restart && !cif.count_up && !cif.hit && cif.tick && down_last)
        |=> (cif.expire && cif.count == $past(cif.load_value)))
        else $error("down counter did not expire and reload");

    a_down_step: assert property (@(posedge i_clk) disable iff (i_reset) // [R3]
        (!restart && !cif.count_up && !cif.hit && cif.tick && !down_last)
        |=> (!cif.expire && cif.count == $past(cnt_ff) - 11'h001))
        else $error("down counter did not step by one");

    a_up_wrap: assert property (@(posedge i_clk) disable iff (i_reset) // [R4]
        (!restart && cif.count_up && cif.hit && terminal_up)
        |=> (cif.expire && cif.count == 11'h000))
        else $error("up counter did not fire and clear at terminal");

    a_idle_quiet: assert property (@(posedge i_clk) disable iff (i_reset) // [R14]
        !cif.active |=> !cif.expire)
        else $error("event raised while counter inactive");

endmodule

// [rtl/arm_pkg.sv]
// Constants shared by the rule qualifier and its event counters
package arm_pkg;

    // Ports served and packet port index width
    localparam int         NUM_PORTS       = 5;
    localparam int         PORT_W          = 3;

    // Directly addressed registers of the indirect access window
    localparam logic [7:0] ADDR_IND_CTRL   = 8'h6e;
    localparam logic [7:0] ADDR_IND_OFS    = 8'h6f;
    localparam logic [7:0] ADDR_IND_DATA   = 8'ha0;
    localparam logic [7:0] IND_CTRL_RST    = 8'h00;
    localparam logic [7:0] IND_OFS_RST     = 8'h00;

    // Indirect control byte layout
    localparam int         TBL_MSB         = 7;
    localparam int         TBL_LSB         = 5;
    localparam int         WPORT_MSB       = 3;
    localparam int         WPORT_LSB       = 0;
    localparam logic [2:0] TBL_ACL         = 3'h2;

    // Rule byte holding mode and enable fields
    localparam logic [7:0] OFS_MODE_ENABLE = 8'h01;
    localparam int         CFG_W           = 6;
    localparam logic [5:0] CFG_RST         = 6'h00;
    localparam int         MODE_MSB        = 5;
    localparam int         MODE_LSB        = 4;
    localparam int         SEL_MSB         = 3;
    localparam int         SEL_LSB         = 2;
    localparam int         SIDE_BIT        = 1;
    localparam int         EQ_BIT          = 0;

    // Filter layer codes
    localparam logic [1:0] LAYER_OFF       = 2'h0;
    localparam logic [1:0] LAYER_L2        = 2'h1;
    localparam logic [1:0] LAYER_L3        = 2'h2;
    localparam logic [1:0] LAYER_L4        = 2'h3;

    // Compare select codes
    localparam logic [1:0] SEL_00          = 2'h0;
    localparam logic [1:0] SEL_01          = 2'h1;
    localparam logic [1:0] SEL_10          = 2'h2;
    localparam logic [1:0] SEL_11          = 2'h3;

    // Forward field bits steering the counter
    localparam int         FWD_UNIT_BIT    = 4;
    localparam int         FWD_ALG_BIT     = 3;

    // Counter width and time base
    localparam int         CNT_W           = 11;
    localparam int         CLK_NS          = 10;
    localparam int         US_NS           = 1000;
    localparam int         US_CYCLES       = (US_NS + CLK_NS - 1) / CLK_NS;
    localparam int         MS_US           = 1000;
    localparam int         MS_CYCLES_DFLT  = MS_US * US_CYCLES;

endpackage

// [rtl/arm_rule_match.sv]
// ACL rule mode/enable qualifier with indirect access window and counters
// Contract
// [R1] Layer 2 with select 00 counts packets whose MAC address and type match.
// [R2] Forward bit 4 picks the count unit: 0 for microseconds, 1 for ms.
// [R3] With forward bit 3 at 0 a loaded counter counts down and fires on expiry.
// [R4] With forward bit 3 at 1 matches count up, fire at terminal, then clear.
// [R5] Layer 2 select 01 tests type, 10 tests address, 11 tests both.
// [R6] Layer 3 select 01 tests masked IP address or protocol; 00 and 11 unused.
// [R7] Layer 3 select 10 tests source and destination IP under the equal bit.
// [R8] Layer 4 select 00 tests protocol; 01 and 10 test TCP/UDP ports.
// [R9] Layer 4 select 11 tests the TCP sequence number.
// [R10] The side bit compares the destination address at 0, the source at 1.
// [R11] The equal bit matches on difference at 0 and on equality at 1.
// [R12] Rule bytes are reached via table 010, port, offset and a data window.
// [R13] Mode 00 disables the rule, 01 layer 2, 10 layer 3, 11 layer 4.
// [R14] Each expiry or terminal count yields one single-cycle event.
`timescale 1ns/100ps
module arm_rule_match #(
    parameter int MS_CYCLES = arm_pkg::MS_CYCLES_DFLT
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_reset,
    input  wire logic [7:0]                 i_reg_addr,
    input  wire logic                       i_reg_wr,
    input  wire logic                       i_reg_rd,
    input  wire logic [7:0]                 i_reg_wdata,
    output logic      [7:0]                 o_reg_rdata,
    output logic                            o_reg_rvalid,
    input  wire logic                       i_pkt_valid,
    input  wire logic [arm_pkg::PORT_W-1:0] i_pkt_port,
    input  wire logic                       i_mac_da_eq,
    input  wire logic                       i_mac_sa_eq,
    input  wire logic                       i_type_eq,
    input  wire logic                       i_ip_da_eq,
    input  wire logic                       i_ip_sa_eq,
    input  wire logic                       i_ip_proto_eq,
    input  wire logic                       i_proto_eq,
    input  wire logic                       i_l4_dport_eq,
    input  wire logic                       i_l4_sport_eq,
    input  wire logic                       i_tcp_seq_eq,
    input  wire logic [arm_pkg::NUM_PORTS-1:0][arm_pkg::CNT_W-1:0]
                                            i_action_count,
    input  wire logic [arm_pkg::NUM_PORTS-1:0][7:0]
                                            i_fwd_field,
    output logic                            o_match_valid,
    output logic                            o_match,
    output logic      [arm_pkg::PORT_W-1:0] o_match_port,
    output logic      [arm_pkg::NUM_PORTS-1:0]
                                            o_count_event,
    output logic      [arm_pkg::NUM_PORTS-1:0][arm_pkg::CNT_W-1:0]
                                            o_count
);
    import arm_pkg::*;

    localparam int MS_W = $clog2(MS_CYCLES);
    localparam int US_W = $clog2(US_CYCLES);

    // Result of one rule test: whether the selection is legal, and equality
    typedef struct packed {
        logic valid;
        logic equal;
    } arm_cmp_type;

    // Compare-set decode, shared by the match path and the counter qualifier
    function automatic arm_cmp_type cmp_decode(
        input logic [1:0] layer,
        input logic [1:0] sel,
        input logic       side,
        input logic       mac_da,
        input logic       mac_sa,
        input logic       mtype,
        input logic       ip_da,
        input logic       ip_sa,
        input logic       ip_proto,
        input logic       proto,
        input logic       l4_dport,
        input logic       l4_sport,
        input logic       tcp_seq
    );
        arm_cmp_type r;
        logic        mac_addr;
        logic        ip_addr;
        logic        l4_port;
        r        = '0;
        mac_addr = side ? mac_sa : mac_da; // [R10]
        ip_addr  = side ? ip_sa : ip_da; // [R10]
        l4_port  = side ? l4_sport : l4_dport; // [R10]
        case (layer) // [R13]
            LAYER_L2: begin
                r.valid = 1'b1;
                case (sel)
                    SEL_01:  r.equal = mtype; // [R5]
                    SEL_10:  r.equal = mac_addr; // [R5]
                    default: r.equal = mac_addr && mtype; // [R5] [R1]
                endcase
            end
            LAYER_L3: begin
                case (sel)
                    SEL_01: begin
                        r.valid = 1'b1;
                        r.equal = ip_addr || ip_proto; // [R6]
                    end
                    SEL_10: begin
                        r.valid = 1'b1;
                        r.equal = ip_sa && ip_da; // [R7]
                    end
                    default: r.valid = 1'b0; // [R6]
                endcase
            end
            LAYER_L4: begin
                r.valid = 1'b1;
                case (sel)
                    SEL_00:  r.equal = proto; // [R8]
                    SEL_11:  r.equal = tcp_seq; // [R9]
                    default: r.equal = l4_port; // [R8]
                endcase
            end
            default: r.valid = 1'b0; // [R13]
        endcase
        return r;
    endfunction

    logic [7:0]       ctrl_ff;
    logic [7:0]       ofs_ff;
    logic [CFG_W-1:0] cfg_ff [NUM_PORTS];
    logic [7:0]       rdata_ff;
    logic             rvalid_ff;
    logic             mvalid_ff;
    logic             match_ff;
    logic [PORT_W-1:0] mport_ff;
    logic [US_W-1:0]  us_cnt_ff;
    logic [MS_W-1:0]  ms_cnt_ff;
    logic             us_tick_ff;
    logic             ms_tick_ff;

    // Indirect window decode
    wire logic [3:0]       win_port;
    wire logic             win_hit;
    wire logic             win_wr;
    wire logic [7:0]       win_rdata;
    wire logic [7:0]       rd_mux;

    assign win_port  = ctrl_ff[WPORT_MSB:WPORT_LSB];
    assign win_hit   = (ctrl_ff[TBL_MSB:TBL_LSB] == TBL_ACL) &&
                       (win_port < 4'(NUM_PORTS)) &&
                       (ofs_ff == OFS_MODE_ENABLE); // [R12]
    assign win_wr    = i_reg_wr && (i_reg_addr == ADDR_IND_DATA) && win_hit;
    // Reserved bits 7:6 read zero; other rule bytes live outside this block
    assign win_rdata = win_hit ? {2'h0, cfg_ff[win_port[PORT_W-1:0]]}
                               : 8'h00; // [R12]
    assign rd_mux    = (i_reg_addr == ADDR_IND_CTRL) ? ctrl_ff :
                       (i_reg_addr == ADDR_IND_OFS)  ? ofs_ff  :
                       (i_reg_addr == ADDR_IND_DATA) ? win_rdata : 8'h00;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ctrl_ff <= IND_CTRL_RST;
            ofs_ff  <= IND_OFS_RST;
        end else if (i_reg_wr && i_reg_addr == ADDR_IND_CTRL) begin
            ctrl_ff <= i_reg_wdata; // [R12]
        end else if (i_reg_wr && i_reg_addr == ADDR_IND_OFS) begin
            ofs_ff  <= i_reg_wdata; // [R12]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                cfg_ff[p] <= CFG_RST;
            end
        end else if (win_wr) begin
            cfg_ff[win_port[PORT_W-1:0]] <= i_reg_wdata[CFG_W-1:0]; // [R12]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdata_ff  <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff  <= i_reg_rd ? rd_mux : rdata_ff;
            rvalid_ff <= i_reg_rd;
        end
    end

    assign o_reg_rdata  = rdata_ff;
    assign o_reg_rvalid = rvalid_ff;

    // Packet path: rule of the arriving port
    wire logic             pkt_ok;
    wire logic [CFG_W-1:0] pkt_cfg;
    wire arm_cmp_type      pkt_cmp;
    wire logic             pkt_match;

    assign pkt_ok    = i_pkt_valid && (i_pkt_port < PORT_W'(NUM_PORTS));
    assign pkt_cfg   = pkt_ok ? cfg_ff[i_pkt_port] : CFG_RST;
    assign pkt_cmp   = cmp_decode(pkt_cfg[MODE_MSB:MODE_LSB],
                                  pkt_cfg[SEL_MSB:SEL_LSB],
                                  pkt_cfg[SIDE_BIT],
                                  i_mac_da_eq, i_mac_sa_eq, i_type_eq,
                                  i_ip_da_eq, i_ip_sa_eq, i_ip_proto_eq,
                                  i_proto_eq, i_l4_dport_eq, i_l4_sport_eq,
                                  i_tcp_seq_eq);
    assign pkt_match = pkt_cmp.valid &&
                       (pkt_cfg[EQ_BIT] ? pkt_cmp.equal
                                        : !pkt_cmp.equal); // [R11] [R7]

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mvalid_ff <= 1'b0;
            match_ff  <= 1'b0;
            mport_ff  <= {PORT_W{1'b0}};
        end else begin
            mvalid_ff <= pkt_ok;
            match_ff  <= pkt_ok && pkt_match;
            mport_ff  <= pkt_ok ? i_pkt_port : mport_ff;
        end
    end

    assign o_match_valid = mvalid_ff;
    assign o_match       = match_ff;
    assign o_match_port  = mport_ff;

    // Time base: ms counts cycles directly so a bench can shorten it
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            us_cnt_ff  <= {US_W{1'b0}};
            us_tick_ff <= 1'b0;
        end else begin
            us_tick_ff <= us_cnt_ff == US_W'(US_CYCLES - 1);
            us_cnt_ff  <= (us_cnt_ff == US_W'(US_CYCLES - 1)) ? {US_W{1'b0}}
                          : us_cnt_ff + {{(US_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ms_cnt_ff  <= {MS_W{1'b0}};
            ms_tick_ff <= 1'b0;
        end else begin
            ms_tick_ff <= ms_cnt_ff == MS_W'(MS_CYCLES - 1);
            ms_cnt_ff  <= (ms_cnt_ff == MS_W'(MS_CYCLES - 1)) ? {MS_W{1'b0}}
                          : ms_cnt_ff + {{(MS_W-1){1'b0}}, 1'b1};
        end
    end

    // Counter qualifier uses raw equality, independent of the equal bit
    wire logic pkt_count_hit;
    assign pkt_count_hit = pkt_ok && pkt_cmp.valid && pkt_cmp.equal &&
                           (pkt_cfg[MODE_MSB:MODE_LSB] == LAYER_L2) &&
                           (pkt_cfg[SEL_MSB:SEL_LSB] == SEL_00); // [R1]

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        arm_cnt_if cif ();

        assign cif.active     = (cfg_ff[p][MODE_MSB:MODE_LSB] == LAYER_L2) &&
                                (cfg_ff[p][SEL_MSB:SEL_LSB] == SEL_00); // [R1]
        assign cif.count_up   = i_fwd_field[p][FWD_ALG_BIT]; // [R3] [R4]
        assign cif.tick       = i_fwd_field[p][FWD_UNIT_BIT] ? ms_tick_ff
                                                             : us_tick_ff; // [R2]
        assign cif.hit        = pkt_count_hit &&
                                (i_pkt_port == PORT_W'(p)); // [R1]
        assign cif.load_value = i_action_count[p]; // [R1]

        arm_event_counter u_counter (
            .i_clk   (i_clk),
            .i_reset (i_reset),
            .cif     (cif.counter)
        );

        assign o_count_event[p] = cif.expire; // [R14]
        assign o_count[p]       = cif.count;
    end

    a_win_write: assert property (@(posedge i_clk) disable iff (i_reset) // [R12]
        win_wr |=> (cfg_ff[$past(win_port[PORT_W-1:0])] ==
                    $past(i_reg_wdata[CFG_W-1:0])))
        else $error("window write did not reach the rule byte");

    a_win_reserved: assert property (@(posedge i_clk) disable iff (i_reset) // [R12]
        (i_reg_rd && i_reg_addr == ADDR_IND_DATA)
        |=> (o_reg_rvalid && o_reg_rdata[7:6] == 2'h0))
        else $error("reserved bits of rule byte read nonzero");

    a_mode_off: assert property (@(posedge i_clk) disable iff (i_reset) // [R13]
        (pkt_ok && pkt_cfg[MODE_MSB:MODE_LSB] == LAYER_OFF)
        |=> (o_match_valid && !o_match))
        else $error("disabled rule produced a match");

    a_l3_reserved: assert property (@(posedge i_clk) disable iff (i_reset) // [R6]
        (pkt_ok && pkt_cfg[MODE_MSB:MODE_LSB] == LAYER_L3 &&
         (pkt_cfg[SEL_MSB:SEL_LSB] == SEL_00 ||
          pkt_cfg[SEL_MSB:SEL_LSB] == SEL_11))
        |=> !o_match)
        else $error("reserved layer 3 select produced a match");

    a_l2_side_da: assert property (@(posedge i_clk) disable iff (i_reset) // [R10]
        (pkt_ok && pkt_cfg == 6'h19 && i_mac_da_eq && !i_mac_sa_eq)
        |=> o_match)
        else $error("layer 2 address test ignored the side bit");

    a_l4_seq_neq: assert property (@(posedge i_clk) disable iff (i_reset) // [R11]
        (pkt_ok && pkt_cfg == 6'h3c && !i_tcp_seq_eq)
        |=> o_match)
        else $error("not-equal polarity failed on sequence test");

    a_us_period: assert property (@(posedge i_clk) disable iff (i_reset) // [R2]
        us_tick_ff |=> (!us_tick_ff [*8]) ##92 us_tick_ff)
        else $error("microsecond tick period wrong");

endmodule

// [tb/test_arm_rule_match.sv]
// Self-checking bench for the ACL rule qualifier
`timescale 1ns/100ps
module test_arm_rule_match;
    import arm_pkg::*;
    // Short ms period keeps the run brief
    localparam int MSC = 200;
    logic                            i_clk = 1'b0;
    logic                            i_reset = 1'b1;
    logic [7:0]                      addr = 8'h00;
    logic [7:0]                      wdata = 8'h00;
    logic                            wr = 1'b0;
    logic                            rd = 1'b0;
    logic                            pv = 1'b0;
    logic [PORT_W-1:0]               pp = '0;
    logic [9:0]                      f = '0;
    logic [NUM_PORTS-1:0][CNT_W-1:0] act = '0;
    logic [NUM_PORTS-1:0][7:0]       fwd = '0;
    logic [7:0]                      rdata;
    logic                            rvalid;
    logic                            mv;
    logic                            m;
    logic [PORT_W-1:0]               mport;
    logic [NUM_PORTS-1:0]            cev;
    logic [NUM_PORTS-1:0][CNT_W-1:0] cnt;
    logic [5:0]                      cfg [NUM_PORTS];
    logic [7:0]                      q_reg [$];
    logic [3:0]                      q_m [$];
    logic [31:0]                     rs = 32'hf3f416fa;
    logic [7:0]                      er;
    logic [3:0]                      em;
    int                              miscompares = 0;
    int                              n_tests = 0;

    always #5 i_clk = ~i_clk;

    arm_rule_match #(.MS_CYCLES(MSC)) DUT (
        .i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_pkt_valid(pv), .i_pkt_port(pp), .i_mac_da_eq(f[9]),
        .i_mac_sa_eq(f[8]), .i_type_eq(f[7]), .i_ip_da_eq(f[6]),
        .i_ip_sa_eq(f[5]), .i_ip_proto_eq(f[4]), .i_proto_eq(f[3]),
        .i_l4_dport_eq(f[2]), .i_l4_sport_eq(f[1]), .i_tcp_seq_eq(f[0]),
        .i_action_count(act), .i_fwd_field(fwd), .o_match_valid(mv),
        .o_match(m), .o_match_port(mport), .o_count_event(cev),
        .o_count(cnt)
    );

    function automatic logic [31:0] rnd();
        rs = {rs[30:0], ^(rs & 32'h80200003)};
        return rs;
    endfunction

    // Expected result of one packet against a rule byte
    function automatic logic m_exp(input logic [5:0] c, input logic [9:0] x);
        logic e;
        logic ok;
        logic s;
        s = c[1];
        ok = 1'b1;
        e = 1'b0;
        case (c[5:4])
            LAYER_L2: case (c[3:2])
                SEL_01:  e = x[7];
                SEL_10:  e = s ? x[8] : x[9];
                default: e = (s ? x[8] : x[9]) & x[7];
            endcase
            LAYER_L3: begin
                e = (c[3:2] == SEL_01) ? ((s ? x[5] : x[6]) | x[4])
                                       : (x[5] & x[6]);
                ok = (c[3:2] == SEL_01) || (c[3:2] == SEL_10);
            end
            LAYER_L4: case (c[3:2])
                SEL_00:  e = x[3];
                SEL_11:  e = x[0];
                default: e = s ? x[1] : x[2];
            endcase
            default: ok = 1'b0;
        endcase
        return ok & (c[0] ? e : !e);
    endfunction

    task automatic chk(input logic [15:0] seen, exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        if (miscompares == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, d);
        @(negedge i_clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge i_clk);
        wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, exp);
        @(negedge i_clk);
        addr = a;
        rd = 1'b1;
        q_reg.push_back(exp);
        @(negedge i_clk);
        rd = 1'b0;
    endtask

    task automatic set_cfg(input int p, input logic [5:0] c);
        wr_reg(ADDR_IND_CTRL, {TBL_ACL, 1'b0, 4'(p)});
        wr_reg(ADDR_IND_OFS, OFS_MODE_ENABLE);
        // Upper bits random: they must be dropped
        wr_reg(ADDR_IND_DATA, {2'(rnd()), c});
        cfg[p] = c;
    endtask

    // Leaves valid high so packets may follow back to back
    task automatic pkt(input logic [PORT_W-1:0] p, input logic [9:0] x);
        @(negedge i_clk);
        pv = 1'b1;
        pp = p;
        f = x;
        if (p < NUM_PORTS)
            q_m.push_back({p, m_exp(cfg[p], x)});
    endtask

    task automatic pkt_end();
        @(negedge i_clk);
        pv = 1'b0;
    endtask

    // Spacing between two consecutive counter events of one port
    task automatic meas(input int p, input int exp);
        int n;
        repeat (2) begin
            n = 0;
            do begin
                @(posedge i_clk);
                #1;
                n++;
            end while (cev[p] !== 1'b1 && n < 3000);
        end
        chk(16'(n), 16'(exp), "event spacing");
    endtask

    initial forever begin
        @(posedge i_clk);
        #1;
        if (rvalid === 1'b1) begin
            er = q_reg.size() ? q_reg.pop_front() : 8'hxx;
            chk(rdata, er, "rdata");
        end
        if (mv === 1'b1) begin
            em = q_m.size() ? q_m.pop_front() : 4'hx;
            chk(m, em[0], "match");
            chk(mport, em[3:1], "match port");
        end
    end

    initial begin
        #300000;
        miscompares++;
        test_done();
    end

    initial begin
        for (int p = 0; p < NUM_PORTS; p++)
            act[p] = CNT_W'(rnd());
        repeat (3) @(negedge i_clk);
        i_reset = 1'b0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            wr_reg(ADDR_IND_CTRL, {TBL_ACL, 1'b0, 4'(p)});
            wr_reg(ADDR_IND_OFS, OFS_MODE_ENABLE);
            rd_reg(ADDR_IND_DATA, 8'h00);
            set_cfg(p, 6'(rnd()));
            rd_reg(ADDR_IND_DATA, {2'b00, cfg[p]});
        end
        // Window refusals: bad port, bad table, bad offset, unmapped
        wr_reg(ADDR_IND_CTRL, 8'h45);
        rd_reg(ADDR_IND_DATA, 8'h00);
        wr_reg(ADDR_IND_CTRL, 8'h20);
        wr_reg(ADDR_IND_DATA, 8'h3f);
        rd_reg(ADDR_IND_DATA, 8'h00);
        wr_reg(ADDR_IND_CTRL, 8'h40);
        wr_reg(ADDR_IND_OFS, 8'h00);
        rd_reg(ADDR_IND_DATA, 8'h00);
        wr_reg(ADDR_IND_OFS, OFS_MODE_ENABLE);
        rd_reg(ADDR_IND_DATA, {2'b00, cfg[0]});
        rd_reg(8'h10, 8'h00);
        // Every mode, select, side and equal combination
        for (int i = 0; i < 64; i++) begin
            set_cfg(i % NUM_PORTS, 6'(i));
            repeat (3) pkt(PORT_W'(i % NUM_PORTS), 10'(rnd()));
            pkt(PORT_W'(5 + i % 3), 10'(rnd()));
            pkt_end();
        end
        // Count-up: value 3 fires on every third hit
        set_cfg(1, 6'h00);
        fwd[1] = 8'h08;
        act[1] = 11'd3;
        set_cfg(1, 6'h11);
        for (int k = 1; k <= 6; k++) begin
            pkt(PORT_W'(1), 10'h280);
            // Event stands only in the cycle after the hit
            pkt_end();
            chk(16'(cev[1]), 16'(k % 3 == 0), "up event");
            chk(16'(cnt[1]), 16'(k % 3), "up count");
        end
        // Count-down: us then ms unit, no hits in between
        @(negedge i_clk);
        fwd[2] = 8'h00;
        act[2] = 11'd3;
        set_cfg(2, 6'h00);
        set_cfg(2, 6'h11);
        meas(2, 3 * US_CYCLES);
        @(negedge i_clk);
        fwd[2] = 8'h10;
        meas(2, 3 * MSC);
        repeat (3) @(negedge i_clk);
        chk(16'(q_reg.size() + q_m.size()), 16'h0, "pending");
        test_done();
    end
endmodule
